// [hw/test_pattern_color_palette.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tpcp_defs.svh"

// Function
// - Bar 3 sends palette byte 3
// - Bar 4 sends palette byte 4
// - Bar 5 sends palette byte 5
// - Bar 6 sends palette byte 6
// - Bar 7 sends palette byte 7
// - Fixed bytes four to eight from 3-7
// - Fixed bytes nine-twelve from 8-11, bars never
// - Fixed bytes thirteen-sixteen from 12-15
// - Bars 0-2, fixed bytes 1-3 from 0-2
module test_pattern_color_palette
    import tpcp_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic             PREADY_O,
    output logic [31:0]      PRDATA_O,
    output logic             PSLVERR_O,
    input  wire logic        LINE_START_I,
    input  wire logic        BYTE_STEP_I,
    output logic [7:0]       DATA_O,
    output logic             DATA_VALID_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    byte_t                      pal_q [`TPCP_NUM_COLORS];
    mode_t                      mode_q;
    logic [15:0]                bar_width_q;
    logic [15:0]                bar_cnt_q;
    logic [2:0]                 bar_q;
    logic [`TPCP_POS_W-1:0]     pos_q;
    apb_state_t                 apb_q;
    logic [31:0]                prdata_q;
    logic                       pslverr_q;
    byte_t                      data_q;
    logic                       valid_q;
    logic [`TPCP_IDX_W-1:0]     idx;
    logic                       is_color;
    logic                       do_write;
    logic [15:0]                bar_cnt_eff;
    logic [2:0]                 bar_eff;
    logic [`TPCP_POS_W-1:0]     pos_eff;
    logic [15:0]                width_m1;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Reset value of one palette byte
    function automatic byte_t color_reset(input int unsigned n);
        byte_t v;
        case (n)
            0:       v = `TPCP_RST_COLOR0;
            1:       v = `TPCP_RST_COLOR1;
            2:       v = `TPCP_RST_COLOR2;
            3:       v = `TPCP_RST_COLOR3;
            4:       v = `TPCP_RST_COLOR4;
            5:       v = `TPCP_RST_COLOR5;
            6:       v = `TPCP_RST_COLOR6;
            7:       v = `TPCP_RST_COLOR7;
            default: v = `TPCP_RST_OTHER;
        endcase
        return v;
    endfunction : color_reset

    // Index decode for the palette window
    function automatic logic in_palette(input logic [`TPCP_IDX_W-1:0] i);
        return (i >= `TPCP_IDX_COLOR0) && (i <= `TPCP_IDX_COLOR15);
    endfunction : in_palette

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Word index and write strobe at the completing edge
    assign idx      = PADDR_I[`TPCP_IDX_W+1:2];
    assign is_color = in_palette(idx);
    assign do_write = PSEL_I && PENABLE_I && PWRITE_I && (apb_q == APB_ANS) && PSTRB_I[0];

    // One wait state, then the answer
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            apb_q <= APB_IDLE;
        end else begin
            case (apb_q)
                APB_IDLE: begin
                    if (PSEL_I && PENABLE_I) begin
                        apb_q <= APB_ANS;
                    end
                end
                APB_ANS: begin
                    apb_q <= APB_IDLE;
                end
                default: begin
                    apb_q <= APB_IDLE;
                end
            endcase
        end
    end

    assign PREADY_O = (apb_q == APB_ANS);

    // Read data and error captured in the wait state
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (PSEL_I && PENABLE_I && (apb_q == APB_IDLE)) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            if (is_color) begin
                prdata_q[7:0] <= pal_q[idx[`TPCP_POS_W-1:0]];
            end else if (idx == `TPCP_IDX_CTRL) begin
                prdata_q[`TPCP_CTRL_MODE_MSB:`TPCP_CTRL_MODE_LSB] <= mode_q;
            end else if (idx == `TPCP_IDX_BAR_WIDTH) begin
                prdata_q[15:0] <= bar_width_q;
            end else if (idx == `TPCP_IDX_STATUS) begin
                prdata_q[`TPCP_STAT_POS_LSB+:`TPCP_POS_W] <= pos_q;
                prdata_q[`TPCP_STAT_BAR_LSB+:3]           <= bar_q;
                prdata_q[`TPCP_STAT_MODE_LSB+:2]          <= mode_q;
            end else begin
                pslverr_q <= 1'b1;
            end
        end
    end

    assign PRDATA_O  = prdata_q;
    assign PSLVERR_O = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Palette bytes 0 to 15
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            for (int n = 0; n < `TPCP_NUM_COLORS; n++) begin
                pal_q[n] <= color_reset(n);
            end
        end else if (do_write && is_color) begin
            pal_q[idx[`TPCP_POS_W-1:0]] <= PWDATA_I[7:0];
        end
    end

    // Mode select
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mode_q <= MODE_OFF;
        end else if (do_write && (idx == `TPCP_IDX_CTRL)) begin
            case (PWDATA_I[`TPCP_CTRL_MODE_MSB:`TPCP_CTRL_MODE_LSB])
                MODE_BAR:   mode_q <= MODE_BAR;
                MODE_FIXED: mode_q <= MODE_FIXED;
                default:    mode_q <= MODE_OFF;
            endcase
        end
    end

    // Bar width in bytes, two lanes
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            bar_width_q <= `TPCP_RST_BAR_WIDTH;
        end else if (PSEL_I && PENABLE_I && PWRITE_I && (apb_q == APB_ANS) && (idx == `TPCP_IDX_BAR_WIDTH)) begin
            if (PSTRB_I[0]) begin
                bar_width_q[7:0] <= PWDATA_I[7:0];
            end
            if (PSTRB_I[1]) begin
                bar_width_q[15:8] <= PWDATA_I[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern sequencing

    // Line start restarts counters in the same cycle
    assign bar_cnt_eff = LINE_START_I ? 16'h0000 : bar_cnt_q;
    assign bar_eff     = LINE_START_I ? 3'h0 : bar_q;
    assign pos_eff     = LINE_START_I ? 4'h0 : pos_q;
    assign width_m1    = (bar_width_q == 16'h0000) ? 16'h0000 : bar_width_q - 16'h0001;

    // Fixed pattern position wraps after byte sixteen
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pos_q <= 4'h0;
        end else if (BYTE_STEP_I && (mode_q == MODE_FIXED)) begin
            pos_q <= pos_eff + 4'h1;
        end else if (LINE_START_I) begin
            pos_q <= 4'h0;
        end
    end

    // Bar counters, eight bars repeat across the line
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            bar_cnt_q <= 16'h0000;
            bar_q     <= 3'h0;
        end else if (BYTE_STEP_I && (mode_q == MODE_BAR)) begin
            if (bar_cnt_eff >= width_m1) begin
                bar_cnt_q <= 16'h0000;
                bar_q     <= (bar_eff == `TPCP_BAR_LAST) ? 3'h0 : bar_eff + 3'h1;
            end else begin
                bar_cnt_q <= bar_cnt_eff + 16'h0001;
                bar_q     <= bar_eff;
            end
        end else if (LINE_START_I) begin
            bar_cnt_q <= 16'h0000;
            bar_q     <= 3'h0;
        end
    end

    // Output byte, bars use only bytes 0-7
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            data_q  <= 8'h00;
            valid_q <= 1'b0;
        end else if (BYTE_STEP_I && (mode_q == MODE_BAR)) begin
            data_q  <= pal_q[{1'b0, bar_eff}];
            valid_q <= 1'b1;
        end else if (BYTE_STEP_I && (mode_q == MODE_FIXED)) begin
            data_q  <= pal_q[pos_eff];
            valid_q <= 1'b1;
        end else begin
            data_q  <= 8'h00;
            valid_q <= 1'b0;
        end
    end

    assign DATA_O       = data_q;
    assign DATA_VALID_O = valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence bar_step_s;
        BYTE_STEP_I && (mode_q == MODE_BAR);
    endsequence

    sequence fix_step_s;
        BYTE_STEP_I && (mode_q == MODE_FIXED);
    endsequence

    sequence line_only_s;
        LINE_START_I && !BYTE_STEP_I;
    endsequence

    bar3_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h3)) |=> DATA_VALID_O && (DATA_O == $past(pal_q[3])))
        else $error("bar 3 byte wrong");

    bar4_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h4)) |=> DATA_O == $past(pal_q[4]))
        else $error("bar 4 byte wrong");

    bar5_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h5)) |=> DATA_O == $past(pal_q[5]))
        else $error("bar 5 byte wrong");

    bar6_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h6)) |=> DATA_O == $past(pal_q[6]))
        else $error("bar 6 byte wrong");

    bar7_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h7)) |=> DATA_O == $past(pal_q[7]))
        else $error("bar 7 byte wrong");

    fixed_mid_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'h3)) |=> DATA_O == $past(pal_q[3]))
        else $error("fixed byte four wrong");

    fixed_upper_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'h8)) |=> DATA_O == $past(pal_q[8]))
        else $error("fixed byte nine wrong");

    fixed_last_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'hF)) |=> (DATA_O == $past(pal_q[15])) && (pos_q == 4'h0))
        else $error("fixed byte sixteen wrong");

    low_bytes_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and LINE_START_I) |=> DATA_O == $past(pal_q[0]))
        else $error("bar 0 byte wrong");

    fixed_cycle_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and !LINE_START_I) |=> pos_q == $past(pos_q) + 4'h1)
        else $error("fixed position not advancing");

    bar_range_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        bar_step_s |=> DATA_VALID_O && (DATA_O == $past(pal_q[bar_eff])))
        else $error("bar byte outside bars 0-7");

    bar1_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h1)) |=> DATA_O == $past(pal_q[1]))
        else $error("bar 1 byte wrong");

    bar2_value_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == 3'h2)) |=> DATA_O == $past(pal_q[2]))
        else $error("bar 2 byte wrong");

    fixed_first_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and LINE_START_I) |=> (DATA_O == $past(pal_q[0])) && (pos_q == 4'h1))
        else $error("fixed byte one wrong");

    fixed_eighth_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'h7)) |=> DATA_O == $past(pal_q[7]))
        else $error("fixed byte eight wrong");

    fixed_twelfth_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'hB)) |=> DATA_O == $past(pal_q[11]))
        else $error("fixed byte twelve wrong");

    fixed_thirteenth_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (fix_step_s and (pos_eff == 4'hC)) |=> DATA_O == $past(pal_q[12]))
        else $error("fixed byte thirteen wrong");

    bar_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and !LINE_START_I and (bar_cnt_q < width_m1)) |=>
            (bar_q == $past(bar_q)) && (bar_cnt_q == $past(bar_cnt_q) + 16'h0001))
        else $error("bar ended early");

    bar_wrap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bar_step_s and (bar_eff == `TPCP_BAR_LAST) and (bar_cnt_eff >= width_m1)) |=> bar_q == 3'h0)
        else $error("bar index not wrapping");

    line_restart_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        line_only_s |=> (pos_q == 4'h0) && (bar_q == 3'h0) && (bar_cnt_q == 16'h0000))
        else $error("line start not restarting");

    idle_output_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !(BYTE_STEP_I && (mode_q != MODE_OFF)) |=> !DATA_VALID_O && (DATA_O == 8'h00))
        else $error("output without a step");

    apb_answer_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O)
        else $error("bus answer late");

endmodule : test_pattern_color_palette

`default_nettype wire

// [include/tpcp_defs.svh]
`ifndef TPCP_DEFS_SVH
`define TPCP_DEFS_SVH

// Palette size and register index width
`define TPCP_NUM_COLORS     16
`define TPCP_POS_W          4
`define TPCP_IDX_W          6
`define TPCP_BAR_LAST       3'h7

// Register indices; byte address is four times the index
`define TPCP_IDX_COLOR0     6'h10
`define TPCP_IDX_COLOR1     6'h11
`define TPCP_IDX_COLOR2     6'h12
`define TPCP_IDX_COLOR3     6'h13
`define TPCP_IDX_COLOR4     6'h14
`define TPCP_IDX_COLOR5     6'h15
`define TPCP_IDX_COLOR6     6'h16
`define TPCP_IDX_COLOR7     6'h17
`define TPCP_IDX_COLOR8     6'h18
`define TPCP_IDX_COLOR9     6'h19
`define TPCP_IDX_COLOR10    6'h1A
`define TPCP_IDX_COLOR11    6'h1B
`define TPCP_IDX_COLOR12    6'h1C
`define TPCP_IDX_COLOR13    6'h1D
`define TPCP_IDX_COLOR14    6'h1E
`define TPCP_IDX_COLOR15    6'h1F
`define TPCP_IDX_CTRL       6'h20
`define TPCP_IDX_BAR_WIDTH  6'h21
`define TPCP_IDX_STATUS     6'h22

// Palette reset values
`define TPCP_RST_COLOR0     8'hAA
`define TPCP_RST_COLOR1     8'h33
`define TPCP_RST_COLOR2     8'h00
`define TPCP_RST_COLOR3     8'h7F
`define TPCP_RST_COLOR4     8'h55
`define TPCP_RST_COLOR5     8'hCC
`define TPCP_RST_COLOR6     8'h0F
`define TPCP_RST_COLOR7     8'h80
`define TPCP_RST_OTHER      8'h00

// Bar width reset value, control and status field positions
`define TPCP_RST_BAR_WIDTH  16'h00A0
`define TPCP_CTRL_MODE_LSB  0
`define TPCP_CTRL_MODE_MSB  1
`define TPCP_STAT_POS_LSB   0
`define TPCP_STAT_BAR_LSB   4
`define TPCP_STAT_MODE_LSB  8

`endif

// [include/tpcp_pkg.sv]
package tpcp_pkg;

    // Pattern mode, Gray-coded along off -> bar -> fixed
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_BAR   = 2'b01,
        MODE_FIXED = 2'b11
    } mode_t;

    // Bus slave phase
    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_ANS  = 1'b1
    } apb_state_t;

    typedef logic [7:0] byte_t;

endpackage : tpcp_pkg

// [sim/test_pattern_color_palette_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tpcp_defs.svh"

module test_pattern_color_palette_bench
    import tpcp_pkg::*;
;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'hF;
    logic        line_start = 1'b0;
    logic        byte_step  = 1'b0;
    wire logic        pready;
    wire logic [31:0] prdata;
    wire logic        pslverr;
    wire logic [7:0]  data;
    wire logic        data_valid;
    int          fails        = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    byte_t       pal [16];
    byte_t       exp_q [32];
    logic [31:0] rd;
    logic        err;

    test_pattern_color_palette uut (
        .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
        .PSLVERR_O(pslverr), .LINE_START_I(line_start), .BYTE_STEP_I(byte_step), .DATA_O(data),
        .DATA_VALID_O(data_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        forever #25 clk = ~clk;
    end

    // Cut a hung run short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task check(input logic [31:0] got, input logic [31:0] expv);
        total_checks++;
        if (got !== expv) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, expv);
            fails++;
        end
    endtask : check

    // One APB transfer, held until the ready edge
    task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wdata);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        // Ready is sampled at each rising edge; the answer is taken at that edge
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Step n bytes back to back, line start with the first step; on says whether exp_q is due
    task stream(input int n, input logic on);
        for (int i = 0; i <= n + 1; i++) begin
            @(posedge clk);
            byte_step  <= (i < n);
            line_start <= (i == 0);
            @(negedge clk);
            if (i > 0 && i <= n) begin
                check({31'h0, data_valid}, {31'h0, on});
                check({24'h0, data}, on ? {24'h0, exp_q[i-1]} : 32'h0);
            end
            if (i == n + 1) begin
                check({31'h0, data_valid}, 32'h0);
                check({24'h0, data}, 32'h0);
            end
        end
    endtask : stream

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task reset_values;
        for (int k = 0; k < 16; k++) exp_q[k] = `TPCP_RST_OTHER;
        exp_q[0] = `TPCP_RST_COLOR0;
        exp_q[1] = `TPCP_RST_COLOR1;
        exp_q[2] = `TPCP_RST_COLOR2;
        exp_q[3] = `TPCP_RST_COLOR3;
        exp_q[4] = `TPCP_RST_COLOR4;
        exp_q[5] = `TPCP_RST_COLOR5;
        exp_q[6] = `TPCP_RST_COLOR6;
        exp_q[7] = `TPCP_RST_COLOR7;
        for (int k = 0; k < 16; k++) begin
            apb(1'b0, 6'(`TPCP_IDX_COLOR0 + k), 32'h0);
            check(rd, {24'h0, exp_q[k]});
            check({31'h0, err}, 32'h0);
        end
        // Mode off after reset: stepping yields nothing
        stream(2, 1'b0);
    endtask : reset_values

    task fixed_pattern;
        for (int k = 0; k < 16; k++) begin
            pal[k] = {4'(k), ~4'(k)};
            apb(1'b1, 6'(`TPCP_IDX_COLOR0 + k), {24'hFFFFFF, pal[k]});
        end
        for (int k = 3; k < 16; k++) begin
            apb(1'b0, 6'(`TPCP_IDX_COLOR0 + k), 32'h0);
            check(rd, {24'h0, pal[k]});
        end
        apb(1'b1, `TPCP_IDX_CTRL, 32'h3);
        for (int k = 0; k < 18; k++) exp_q[k] = pal[k % 16];
        stream(18, 1'b1);
        // Eighteen steps wrap the position round to byte three
        apb(1'b0, `TPCP_IDX_STATUS, 32'h0);
        check(rd, (32'(MODE_FIXED) << `TPCP_STAT_MODE_LSB) | 32'h2);
        // A new line restarts at byte one
        stream(4, 1'b1);
    endtask : fixed_pattern

    task bar_pattern;
        apb(1'b1, `TPCP_IDX_BAR_WIDTH, 32'h2);
        apb(1'b1, `TPCP_IDX_CTRL, 32'h1);
        for (int k = 0; k < 18; k++) exp_q[k] = pal[(k / 2) % 8];
        stream(18, 1'b1);
        // Nine bars of two bytes: the bar index wrapped to bar one
        apb(1'b0, `TPCP_IDX_STATUS, 32'h0);
        check(rd, (32'(MODE_BAR) << `TPCP_STAT_MODE_LSB) | (32'h1 << `TPCP_STAT_BAR_LSB));
        // Zero width counts as one byte per bar
        apb(1'b1, `TPCP_IDX_BAR_WIDTH, 32'h0);
        for (int k = 0; k < 10; k++) exp_q[k] = pal[k % 8];
        stream(10, 1'b1);
    endtask : bar_pattern

    task unmapped_access;
        apb(1'b1, 6'h3F, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 6'h3F, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
    endtask : unmapped_access

    task decode_extras;
        // Code 2 on the mode field selects off
        apb(1'b1, `TPCP_IDX_CTRL, 32'h2);
        apb(1'b0, `TPCP_IDX_CTRL, 32'h0);
        check(rd, 32'(MODE_OFF));
        // A write without lane 0 leaves the palette byte alone
        pstrb <= 4'hE;
        apb(1'b1, `TPCP_IDX_COLOR8, 32'h0000_005A);
        pstrb <= 4'hF;
        apb(1'b0, `TPCP_IDX_COLOR8, 32'h0);
        check(rd, {24'h0, pal[8]});
        // Status is read-only and answers without error
        apb(1'b1, `TPCP_IDX_STATUS, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0);
        // Mode off: steps bring no output
        stream(2, 1'b0);
    endtask : decode_extras

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        reset_values();
        fixed_pattern();
        bar_pattern();
        unmapped_access();
        decode_extras();
        summarize();
    end
endmodule : test_pattern_color_palette_bench

`default_nettype wire
